/* verilog/ctc_regs.svh */
// Named constants for the coax transceiver control block.
`ifndef CTC_REGS_SVH
`define CTC_REGS_SVH

// ----------------------------------------------------------------------------
// Clock and derived rates
// ----------------------------------------------------------------------------
`define CTC_CLK_PERIOD_NS   40
`define CTC_BIT_TIME_NS     100
// The bit tick fires 2 times every 5 cycles (10 MHz from 25 MHz).
`define CTC_BIT_NUM         4'h2
`define CTC_BIT_DEN         4'h5
// The collision wave toggles 4 times every 5 cycles (10 MHz square wave).
`define CTC_WAVE_NUM        4'h4
`define CTC_WAVE_DEN        4'h5

// ----------------------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------------------
`define CTC_TX_OFF_NS       190
`define CTC_MIN_PULSE_NS    15
`define CTC_HB_BITS         24'h00000A
`define CTC_JAB_QUIET_MS    500
`define CTC_JABBER_BITS     24'h030D40
`define CTC_CNT_W           24

`endif

/* verilog/ctc_pkg.sv */
// Types shared by the coax transceiver control block.
`default_nettype none

package ctc_pkg;

   typedef enum logic [3:0] {
      CTC_IDLE   = 4'h1,
      CTC_XMIT   = 4'h2,
      CTC_HBEAT  = 4'h4,
      CTC_JABBER = 4'h8
   } ctc_tx_state_type;

endpackage : ctc_pkg

`default_nettype wire

/* verilog/ctc_tick_gen.sv */
// Fractional rate divider giving a one-cycle enable pulse.
`timescale 1ns/10ps
`default_nettype none

module ctc_tick_gen
#(
   parameter logic [3:0] NUM = 4'h1,
   parameter logic [3:0] DEN = 4'h2
)
(
   input  wire logic ref_clk_i,
   input  wire logic arst_n_i,
   output var  logic pulse_o
);

   logic [3:0] acc;
   logic [3:0] next_acc;
   logic       next_pulse;
   logic [3:0] sum;

   always_comb
   begin
      sum        = acc + NUM;
      next_acc   = sum;
      next_pulse = 1'b0;
      if (sum >= DEN)
      begin
         next_acc   = sum - DEN;
         next_pulse = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         acc     <= 4'h0;
         pulse_o <= 1'b0;
      end
      else
      begin
         acc     <= next_acc;
         pulse_o <= next_pulse;
      end
   end

endmodule : ctc_tick_gen

`default_nettype wire

/* verilog/ctc_top.sv */
// Digital control of a 10 Mb/s coax transceiver: transmit, receive, collision, heartbeat, jabber.
`timescale 1ns/10ps
`default_nettype none
`include "ctc_regs.svh"

module ctc_top
#(
   parameter logic [`CTC_CNT_W-1:0] JABBER_BITS  = `CTC_JABBER_BITS,
   parameter logic [`CTC_CNT_W-1:0] QUIET_CYCLES =
      `CTC_CNT_W'(`CTC_JAB_QUIET_MS * 1000000 / `CTC_CLK_PERIOD_NS)
)
(
   input  wire logic ref_clk_i,
   input  wire logic arst_n_i,
   input  wire logic aui_tx_data_i,
   input  wire logic aui_tx_amp_ok_i,
   input  wire logic coax_receive_input_i,
   input  wire logic rx_squelch_open_i,
   input  wire logic col_rx_level_i,
   input  wire logic col_tx_level_i,
   input  wire logic heartbeat_enable_pin_i,
   output var  logic coax_transmit_output_o,
   output var  logic coax_transmit_enable_o,
   output var  logic aui_rx_pos_o,
   output var  logic aui_rx_neg_o,
   output var  logic collision_pair_pos_o,
   output var  logic collision_pair_neg_o,
   output var  logic collision_threshold_o
);

   // -------------------------------------------------------------------------
   // Constants
   // -------------------------------------------------------------------------
   localparam logic [`CTC_CNT_W-1:0] OFF_CYCLES =
      `CTC_CNT_W'((`CTC_TX_OFF_NS + `CTC_CLK_PERIOD_NS - 1) / `CTC_CLK_PERIOD_NS);
   // A pulse must cover this many whole samples, plus one, to pass.
   localparam int MIN_PULSE_CYC =
      (`CTC_MIN_PULSE_NS + `CTC_CLK_PERIOD_NS - 1) / `CTC_CLK_PERIOD_NS;

   // -------------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------------
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic       tx_d_s;
   logic       amp_s;
   logic       rx_d_s;
   logic       rx_open_s;
   logic       col_rx_s;
   logic       col_tx_s;

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
      end
      else
      begin
         sync1 <= {aui_tx_data_i, aui_tx_amp_ok_i, coax_receive_input_i,
                   rx_squelch_open_i, col_rx_level_i, col_tx_level_i};
         sync2 <= sync1;
      end
   end

   assign {tx_d_s, amp_s, rx_d_s, rx_open_s, col_rx_s, col_tx_s} = sync2;

   logic hb_s1;
   logic hb_en;

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         hb_s1 <= 1'b0;
         hb_en <= 1'b0;
      end
      else
      begin
         hb_s1 <= heartbeat_enable_pin_i;
         hb_en <= hb_s1;
      end
   end

   // -------------------------------------------------------------------------
   // Bit tick and collision wave
   // -------------------------------------------------------------------------
   logic bit_tick;
   logic wave_tick;

   ctc_tick_gen #(.NUM(`CTC_BIT_NUM), .DEN(`CTC_BIT_DEN)) u_bit_tick
   (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .pulse_o   (bit_tick)
   );

   ctc_tick_gen #(.NUM(`CTC_WAVE_NUM), .DEN(`CTC_WAVE_DEN)) u_wave_tick
   (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .pulse_o   (wave_tick)
   );

   // -------------------------------------------------------------------------
   // Transmit state machine
   // -------------------------------------------------------------------------
   ctc_pkg::ctc_tx_state_type state;
   ctc_pkg::ctc_tx_state_type next_state;
   logic [`CTC_CNT_W-1:0]     bit_cnt;
   logic [`CTC_CNT_W-1:0]     next_bit_cnt;
   logic [`CTC_CNT_W-1:0]     quiet_cnt;
   logic [`CTC_CNT_W-1:0]     next_quiet_cnt;
   logic [MIN_PULSE_CYC-1:0]  tx_hist;
   logic [MIN_PULSE_CYC-1:0]  next_tx_hist;
   logic                      tx_f;
   logic                      next_tx_f;

   always_comb
   begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_quiet_cnt = amp_s ? `CTC_CNT_W'(0) : quiet_cnt + `CTC_CNT_W'(1);
      next_tx_hist   = tx_hist;
      next_tx_f      = tx_f;
      // Data changes only after it has held for a whole sample interval.
      if (amp_s && (tx_hist == {MIN_PULSE_CYC{tx_d_s}}))
      begin
         next_tx_f = tx_d_s;
      end
      next_tx_hist = MIN_PULSE_CYC'({tx_hist, tx_d_s});
      unique case (state)
         ctc_pkg::CTC_IDLE:
         begin
            next_bit_cnt = `CTC_CNT_W'(0);
            if (amp_s)
            begin
               next_state = ctc_pkg::CTC_XMIT;
            end
         end
         ctc_pkg::CTC_XMIT:
         begin
            if (bit_tick)
            begin
               next_bit_cnt = bit_cnt + `CTC_CNT_W'(1);
            end
            if (bit_cnt >= JABBER_BITS)
            begin
               next_state     = ctc_pkg::CTC_JABBER;
               next_quiet_cnt = `CTC_CNT_W'(0);
            end
            else if (next_quiet_cnt >= OFF_CYCLES)
            begin
               next_bit_cnt = `CTC_CNT_W'(0);
               next_state   = hb_en ? ctc_pkg::CTC_HBEAT : ctc_pkg::CTC_IDLE;
            end
         end
         ctc_pkg::CTC_HBEAT:
         begin
            if (bit_tick)
            begin
               next_bit_cnt = bit_cnt + `CTC_CNT_W'(1);
            end
            if (next_bit_cnt >= `CTC_HB_BITS)
            begin
               next_state = ctc_pkg::CTC_IDLE;
            end
         end
         ctc_pkg::CTC_JABBER:
         begin
            if (next_quiet_cnt >= QUIET_CYCLES)
            begin
               next_state = ctc_pkg::CTC_IDLE;
            end
         end
         default:
         begin
            next_state = ctc_pkg::CTC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state     <= ctc_pkg::CTC_IDLE;
         bit_cnt   <= `CTC_CNT_W'(0);
         quiet_cnt <= `CTC_CNT_W'(0);
         tx_hist   <= '0;
         tx_f      <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         bit_cnt   <= next_bit_cnt;
         quiet_cnt <= next_quiet_cnt;
         tx_hist   <= next_tx_hist;
         tx_f      <= next_tx_f;
      end
   end

   // -------------------------------------------------------------------------
   // Output stage
   // -------------------------------------------------------------------------
   logic xmit;
   logic col_det;
   logic col_req;
   logic next_col_req;
   logic wave;
   logic next_wave;

   assign xmit = (state == ctc_pkg::CTC_XMIT);
   // Threshold follows transmit state.
   assign col_det = xmit ? col_tx_s : col_rx_s;

   always_comb
   begin
      next_wave    = wave_tick ? ~wave : wave;
      next_col_req = col_det || (state == ctc_pkg::CTC_HBEAT) ||
                     (state == ctc_pkg::CTC_JABBER);
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         wave                   <= 1'b0;
         col_req                <= 1'b0;
         collision_pair_pos_o   <= 1'b0;
         collision_pair_neg_o   <= 1'b0;
         collision_threshold_o  <= 1'b0;
         coax_transmit_enable_o <= 1'b0;
         coax_transmit_output_o <= 1'b0;
         aui_rx_pos_o           <= 1'b0;
         aui_rx_neg_o           <= 1'b0;
      end
      else
      begin
         wave                   <= next_wave;
         col_req                <= next_col_req;
         collision_pair_pos_o   <= col_req & wave;
         collision_pair_neg_o   <= col_req & ~wave;
         collision_threshold_o  <= xmit;
         coax_transmit_enable_o <= xmit;
         coax_transmit_output_o <= xmit & tx_f;
         aui_rx_pos_o           <= rx_open_s & rx_d_s;
         aui_rx_neg_o           <= rx_open_s & ~rx_d_s;
      end
   end

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_pair_idle;
      !col_req |=> !collision_pair_pos_o && !collision_pair_neg_o;
   endproperty
   a_pair_idle: assert property (p_pair_idle) else $error("collision pair not idle");

   property p_pair_excl;
      !(collision_pair_pos_o && collision_pair_neg_o);
   endproperty
   a_pair_excl: assert property (p_pair_excl) else $error("pair legs both high");

   property p_hb_gate;
      $rose(state == ctc_pkg::CTC_HBEAT) |-> $past(hb_en);
   endproperty
   a_hb_gate: assert property (p_hb_gate) else $error("heartbeat while disabled");

   property p_hb_len;
      state == ctc_pkg::CTC_HBEAT |-> bit_cnt < `CTC_HB_BITS;
   endproperty
   a_hb_len: assert property (p_hb_len) else $error("heartbeat too long");

   property p_tx_off;
      (xmit && !amp_s && bit_cnt < JABBER_BITS)[*5] |=> !xmit;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("transmitter not turned off");

   property p_jab_quiet;
      state == ctc_pkg::CTC_JABBER |=> !coax_transmit_enable_o && col_req;
   endproperty
   a_jab_quiet: assert property (p_jab_quiet) else $error("jabber did not disable");

   property p_thresh;
      collision_threshold_o == $past(xmit);
   endproperty
   a_thresh: assert property (p_thresh) else $error("threshold select wrong");

   property p_rx_squelch;
      !rx_open_s |=> !aui_rx_pos_o && !aui_rx_neg_o;
   endproperty
   a_rx_squelch: assert property (p_rx_squelch) else $error("receive not squelched");

   property p_col_det;
      col_det |=> col_req ##1 (collision_pair_pos_o || collision_pair_neg_o);
   endproperty
   a_col_det: assert property (p_col_det) else $error("collision not signalled");

   property p_jab_exit;
      (state == ctc_pkg::CTC_JABBER) && amp_s |=> state == ctc_pkg::CTC_JABBER;
   endproperty
   a_jab_exit: assert property (p_jab_exit) else $error("jabber left while active");

   c_xmit:   cover property (xmit ##1 !xmit);
   c_hbeat:  cover property (state == ctc_pkg::CTC_HBEAT);
   c_jabber: cover property (state == ctc_pkg::CTC_JABBER);
   c_col:    cover property (xmit && col_tx_s);

endmodule : ctc_top

`default_nettype wire

/* verification/ctc_mac_model.sv */
// Behavioural model of the MAC that drives the AUI transmit pair.
`timescale 1ns/10ps
`default_nettype none

module ctc_mac_model
(
   input  wire logic clk_i,
   output var  logic data_o,
   output var  logic amp_ok_o
);
   logic pkt;
   logic noise;

   initial
   begin
      pkt      = 1'b0;
      noise    = 1'b0;
      amp_ok_o = 1'b0;
   end

   // A released pair shows noise that flips every cycle, never a held level.
   always @(negedge clk_i) noise <= ~noise;
   always_comb data_o = amp_ok_o ? pkt : noise;

   // Sends halves data edges held hold cycles each; glitch adds a one-cycle spike.
   task automatic send(input int halves, input int hold, input bit glitch);
      @(negedge clk_i);
      amp_ok_o = 1'b1;
      for (int i = 0; i < halves; i++)
      begin
         pkt = ~pkt;
         repeat (hold) @(negedge clk_i);
         if (glitch && i == halves / 2)
         begin
            pkt = ~pkt;
            @(negedge clk_i);
            pkt = ~pkt;
            @(negedge clk_i);
         end
      end
      amp_ok_o = 1'b0;
   endtask : send
endmodule : ctc_mac_model
`default_nettype wire

/* verification/coax_transceiver_control_tb.sv */
// Self-checking testbench of the coax transceiver control block.
`timescale 1ns/10ps
`default_nettype none

module coax_transceiver_control_tb;
   logic       clk;
   logic       arst_n;
   logic       tx_data;
   logic       amp_ok;
   logic       rx_in;
   logic       sq_open;
   logic       crx;
   logic       ctx;
   logic       heartbeat_enable_pin;
   logic       tx_out;
   logic       tx_en;
   logic       rx_pos;
   logic       rx_neg;
   logic       col_pos;
   logic       col_neg;
   logic       thr;
   logic       last_tx;
   logic       last_rx;
   logic [4:0] rows [4];
   int         fail_count;
   int         samples_checked;
   int         tx_tog;
   int         col_cnt;
   int         rx_tog;
   int         rx_eq;
   int         n;
   int         base;

   initial clk = 1'b0;
   always #20 clk = ~clk;

   ctc_top #(.JABBER_BITS(24'h000064), .QUIET_CYCLES(24'h000028)) u_ctc_top
   (
      .ref_clk_i              (clk),
      .arst_n_i               (arst_n),
      .aui_tx_data_i          (tx_data),
      .aui_tx_amp_ok_i        (amp_ok),
      .coax_receive_input_i   (rx_in),
      .rx_squelch_open_i      (sq_open),
      .col_rx_level_i         (crx),
      .col_tx_level_i         (ctx),
      .heartbeat_enable_pin_i (heartbeat_enable_pin),
      .coax_transmit_output_o (tx_out),
      .coax_transmit_enable_o (tx_en),
      .aui_rx_pos_o           (rx_pos),
      .aui_rx_neg_o           (rx_neg),
      .collision_pair_pos_o   (col_pos),
      .collision_pair_neg_o   (col_neg),
      .collision_threshold_o  (thr)
   );

   ctc_mac_model u_ctc_mac_model
   (
      .clk_i    (clk),
      .data_o   (tx_data),
      .amp_ok_o (amp_ok)
   );

   // -------------------------------------------------------------------------
   // Activity monitors
   // -------------------------------------------------------------------------
   always @(posedge clk)
   begin
      if (tx_en === 1'b1 && tx_out !== last_tx) tx_tog++;
      if (col_pos === 1'b1 || col_neg === 1'b1) col_cnt++;
      if (rx_pos !== last_rx) rx_tog++;
      if (rx_pos === rx_neg) rx_eq++;
      last_tx = tx_out;
      last_rx = rx_pos;
   end

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task conclude;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   task cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc

   task zero;
      tx_tog  = 0;
      col_cnt = 0;
      rx_tog  = 0;
      rx_eq   = 0;
   endtask : zero

   initial
   begin
      repeat (5000) @(posedge clk);
      fail_count++;
      conclude();
   end

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial
   begin
      fail_count = 0;
      samples_checked = 0;
      {arst_n, rx_in, sq_open, crx, ctx, heartbeat_enable_pin, last_tx, last_rx} = 8'h00;
      // Columns: transmit, receive level, transmit level, threshold, collision.
      rows[0] = 5'b00000;
      rows[1] = 5'b01001;
      rows[2] = 5'b11010;
      rows[3] = 5'b11111;
      cyc(8);
      arst_n = 1'b1;
      cyc(1);
      check("idle", {tx_out, tx_en, rx_pos, rx_neg, col_pos, col_neg, thr}, 0);
      foreach (rows[i])
      begin
         crx = rows[i][3];
         ctx = rows[i][2];
         if (rows[i][4])
            fork
               u_ctc_mac_model.send(30, 2, 1'b0);
            join_none
         cyc(20);
         check("threshold", thr, rows[i][1]);
         zero();
         cyc(10);
         check("collision", col_cnt != 0, rows[i][0]);
         wait fork;
         crx = 1'b0;
         ctx = 1'b0;
         cyc(20);
      end
      for (int k = 0; k < 2; k++)
      begin
         heartbeat_enable_pin = (k == 0);
         zero();
         u_ctc_mac_model.send(20, 2 + k, k == 1);
         n = 0;
         while (tx_en === 1'b1 && n < 20)
         begin
            @(negedge clk);
            n++;
         end
         check("tx off", n >= 5 && n <= 10, 1);
         // Data edges are counted only while the transmitter is enabled, and checked once it is off.
         if (k == 0)
            base = tx_tog;
         else
            check("glitch", tx_tog, base);
         check("data", tx_tog, 20);
         @(negedge clk);
         zero();
         cyc(60);
         if (k == 0)
            check("heartbeat", col_cnt >= 12 && col_cnt <= 38, 1);
         else
            check("no heartbeat", col_cnt, 0);
      end
      for (int j = 0; j < 2; j++)
      begin
         sq_open = j[0];
         cyc(4);
         zero();
         repeat (10)
         begin
            rx_in = ~rx_in;
            cyc(2);
         end
         if (j == 0)
            check("rx closed", {rx_tog[15:0], rx_eq[15:0]}, 32'h00000014);
         else
            check("rx open", {rx_tog >= 7, rx_eq[15:0]}, 32'h00010000);
      end
      sq_open = 1'b0;
      heartbeat_enable_pin = 1'b0;
      fork
         u_ctc_mac_model.send(150, 2, 1'b0);
      join_none
      cyc(280);
      check("jabber tx", tx_en, 0);
      zero();
      cyc(5);
      check("jabber col", col_cnt, 5);
      wait fork;
      zero();
      cyc(30);
      check("jabber hold", col_cnt, 30);
      cyc(30);
      zero();
      cyc(20);
      check("jabber exit", col_cnt, 0);
      // A reset in mid-run, while a receive-mode collision is signalled.
      crx = 1'b1;
      cyc(8);
      check("collision rx", col_pos | col_neg, 1);
      arst_n = 1'b0;
      cyc(1);
      check("reset", {tx_out, tx_en, rx_pos, rx_neg, col_pos, col_neg, thr}, 0);
      arst_n = 1'b1;
      cyc(1);
      check("after reset", {col_pos, col_neg}, 0);
      cyc(6);
      check("collision again", col_pos | col_neg, 1);
      crx = 1'b0;
      cyc(4);
      conclude();
   end
endmodule : coax_transceiver_control_tb
`default_nettype wire
